// >>> uart_flow_cfg.svh
// Offsets, field positions, reset values and counts for the UART flow-control block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef UART_FLOW_CFG_SVH
`define UART_FLOW_CFG_SVH
`define OFF_FEATURE   8'h00
`define OFF_ENHANCED  8'h04
`define OFF_TX_COUNT  8'h08
`define OFF_TX_TRIG   8'h0c
`define OFF_RX_COUNT  8'h10
`define OFF_RX_TRIG   8'h14
`define OFF_STOP1     8'h18
`define OFF_STOP2     8'h1c
`define OFF_RESUME1   8'h20
`define OFF_RESUME2   8'h24
`define OFF_FLOW_STAT 8'h28
`define OFF_MODEM_CTL 8'h2c
`define OFF_INT_STAT  8'h30
`define RST_BYTE      8'h00
`define FIFO_DEPTH    8'h40
`define NEXT_STEP     8'h04
`define TABLE_D       2'b11
// Table D hysteresis offsets, one byte per four-bit code, code zero in the low byte.
`define HYST_TABLE    128'h24_1c_14_0c_34_30_2c_28_20_18_10_08_08_06_04_00
`define EF_AUTO_CTS   7
`define EF_AUTO_RTS   6
`define EF_SPECIAL    5
`define EF_ENHANCED   4
`define MC_SELECT     2
`define MC_RTS        1
`define MC_DTR        0
`define IS_SPECIAL    4
`endif

// >>> uart_flow_pkg.sv
// Types shared by the UART flow-control block and its character matcher.
// Assumes nothing beyond a SystemVerilog package scope.
`default_nettype none
package uart_flow_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_RESUME_CHAR_FIRST = 2'b01, SEQ_STOP_CHAR_FIRST = 2'b10} seq_state_t;
endpackage
`default_nettype wire

// >>> flow_char_match.sv
// Compares received characters against the stop and resume characters.
// Assumes a synchronous reset copy and one character per valid strobe.
`timescale 1ns/1ps
`default_nettype none
module flow_char_match (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 clock_en,
	input  wire logic [1:0]           tx_mode,
	input  wire logic [1:0]           rx_mode,
	input  wire logic                 special_en,
	input  wire uart_flow_pkg::byte_t stop1,
	input  wire uart_flow_pkg::byte_t stop2,
	input  wire uart_flow_pkg::byte_t resume1,
	input  wire uart_flow_pkg::byte_t resume2,
	input  wire logic                 char_valid,
	input  wire uart_flow_pkg::byte_t char_in,
	output logic                      xon_hit,
	output logic                      xoff_hit,
	output logic                      special_hit,
	output logic                      store_valid,
	output uart_flow_pkg::byte_t      store_char
);
	import uart_flow_pkg::*;
	seq_state_t state;
	logic       one_first, one_second, pair_seq, on_now, off_now;

	// Single-character and two-character compare modes.
	always_comb
	begin
		one_first  = (rx_mode == 2'b10) || (rx_mode == 2'b11 && (tx_mode == 2'b10 || tx_mode == 2'b01));
		one_second = (rx_mode == 2'b01) || (rx_mode == 2'b11 && (tx_mode == 2'b10 || tx_mode == 2'b01));
		pair_seq   = (rx_mode == 2'b11) && (tx_mode == 2'b11 || tx_mode == 2'b00);
		on_now  = (one_first && char_in == resume1) || (one_second && char_in == resume2)
			|| (pair_seq && state == SEQ_RESUME_CHAR_FIRST && char_in == resume2);
		off_now = (one_first && char_in == stop1) || (one_second && char_in == stop2)
			|| (pair_seq && state == SEQ_STOP_CHAR_FIRST && char_in == stop2);
	end

	// Tracks the first half of a two-character sequence.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			state <= SEQ_IDLE;
		else if (clock_en && char_valid)
		begin
			case ({pair_seq, char_in == resume1, char_in == stop1})
				3'b110:  state <= SEQ_RESUME_CHAR_FIRST;
				3'b101:  state <= SEQ_STOP_CHAR_FIRST;
				default: state <= SEQ_IDLE;
			endcase
		end
	end

	// Matched flow characters are consumed, but the first of a pair is stored; a special match in pair-two mode is consumed too.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xon_hit     <= 1'b0;
			xoff_hit    <= 1'b0;
			special_hit <= 1'b0;
			store_valid <= 1'b0;
			store_char  <= 8'h00;
		end
		else if (clock_en)
		begin
			xon_hit     <= char_valid && on_now;
			xoff_hit    <= char_valid && off_now;
			special_hit <= char_valid && special_en && char_in == stop2;
			store_valid <= char_valid && !on_now && !off_now;
			store_char  <= char_in;
		end
	end
endmodule // flow_char_match
`default_nettype wire

// >>> uart_flow_ctrl.sv
// UART channel flow-control registers, FIFO level counters and handshake pins.
// Assumes an APB master on clock, modem pins from outside, FIFO strobes on clock.
// How it works
// - code-table hysteresis applies only with table D and a nonzero code
// - four-bit code maps to fixed character offsets
// - stop above trigger, resume below it
// - auto CTS/DSR high halts the transmitter
// - auto RTS/DTR deasserts above, reasserts below
// - without auto mode the pin follows software
// - modem control bit 2 picks RTS or DTR
// - special character matches second stop character
// - pair-two mode consumes special stop character
// - enhanced bit gates writes to guarded bits
// - reset clears every guarded bit
// - transmit select bits choose character pairs
// - receive select bits choose compare mode
// - transmit level counter reads zero to 64
// - transmit level below trigger raises interrupt
// - receive level counter reads zero to 64
// - receive level reaching trigger raises interrupt
// - four registers hold stop and resume characters
// - status reads zero without software flow control
// - status records last control characters, clears on read
// - tables A to C use next level
//
// The register addresses and the APB slave port are this design's own decisions.
`include "uart_flow_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_flow_ctrl (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 clock_en,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 cts_n,
	input  wire logic                 dsr_n,
	output logic                      rts_n,
	output logic                      dtr_n,
	output logic                      tx_stop,
	output logic      [1:0]           tx_flow_sel,
	input  wire logic                 tx_push,
	input  wire logic                 tx_pop,
	input  wire logic                 rx_pop,
	input  wire logic                 tx_sent_xon,
	input  wire logic                 tx_sent_xoff,
	input  wire logic                 rx_valid,
	input  wire uart_flow_pkg::byte_t rx_char,
	output logic                      rx_store_valid,
	output uart_flow_pkg::byte_t      rx_store_char,
	output logic                      tx_level_irq,
	output logic                      rx_level_irq,
	output logic                      special_irq
);
	import uart_flow_pkg::*;
	logic [1:0] rst_pipe;
	logic       rst_sync_n;
	byte_t      feature_control, enhanced_feature, tx_fifo_trigger, rx_fifo_trigger;
	byte_t      stop_char_first, stop_char_second, resume_char_first, resume_char_second;
	byte_t      modem_control, flow_char_status, interrupt_status;
	byte_t      tx_fifo_level_count, rx_fifo_level_count;
	byte_t      next_rdata, hyst, lo_mark;
	logic [8:0] hi_mark;
	logic       next_err, setup, done, wr, rd, auto_stop, remote_stop;
	logic [1:0] pin_a, pin_b, pin_c, pin_f;
	logic       xon_hit, xoff_hit, special_hit;

	// Reset release passes two flip-flops.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	// Modem inputs pass three flops; a change counts once the last two agree.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sync
			always_ff @(posedge clock or negedge rst_sync_n)
			begin
				if (!rst_sync_n)
					{pin_a[gi], pin_b[gi], pin_c[gi], pin_f[gi]} <= 4'hf;
				else if (clock_en)
				begin
					pin_a[gi] <= (gi == 0) ? cts_n : dsr_n;
					pin_b[gi] <= pin_a[gi];
					pin_c[gi] <= pin_b[gi];
					if (pin_b[gi] == pin_c[gi])
						pin_f[gi] <= pin_c[gi];
				end
			end
		end
	endgenerate

	// Bus phases: answer is ready in the first access cycle.
	assign setup = psel && !penable;
	assign done  = psel && penable && pready;
	assign wr    = done && pwrite;
	assign rd    = done && !pwrite;

	// Read mux; write-only registers read as zero.
	always_comb
	begin
		next_rdata = 8'h00;
		next_err   = 1'b0;
		case (paddr)
			`OFF_FEATURE:   next_rdata = feature_control;
			`OFF_ENHANCED:  next_rdata = enhanced_feature;
			`OFF_TX_COUNT:  next_rdata = tx_fifo_level_count;
			`OFF_RX_COUNT:  next_rdata = rx_fifo_level_count;
			`OFF_FLOW_STAT: next_rdata = flow_char_status;
			`OFF_MODEM_CTL: next_rdata = modem_control;
			`OFF_INT_STAT:  next_rdata = interrupt_status;
			`OFF_TX_TRIG, `OFF_RX_TRIG, `OFF_STOP1, `OFF_STOP2, `OFF_RESUME1, `OFF_RESUME2: next_rdata = 8'h00;
			default:        next_err = 1'b1;
		endcase
	end

	// Answer is captured in the setup cycle and held through the access.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (clock_en)
		begin
			pready <= setup;
			if (setup)
			begin
				pslverr <= next_err;
				prdata  <= {24'h00_0000, pwrite ? 8'h00 : next_rdata};
			end
			else if (done)
				pslverr <= 1'b0;
		end
	end

	// Plain writable registers; only feature and enhanced read back, the others read as zero.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			feature_control    <= `RST_BYTE;
			enhanced_feature   <= `RST_BYTE;
			tx_fifo_trigger    <= `RST_BYTE;
			rx_fifo_trigger    <= `RST_BYTE;
			stop_char_first    <= `RST_BYTE;
			stop_char_second   <= `RST_BYTE;
			resume_char_first  <= `RST_BYTE;
			resume_char_second <= `RST_BYTE;
		end
		else if (clock_en && wr)
		begin
			case (paddr)
				`OFF_FEATURE:  feature_control    <= pwdata[7:0];
				`OFF_ENHANCED: enhanced_feature   <= pwdata[7:0];
				`OFF_TX_TRIG:  tx_fifo_trigger    <= pwdata[7:0];
				`OFF_RX_TRIG:  rx_fifo_trigger    <= pwdata[7:0];
				`OFF_STOP1:    stop_char_first    <= pwdata[7:0];
				`OFF_STOP2:    stop_char_second   <= pwdata[7:0];
				`OFF_RESUME1:  resume_char_first  <= pwdata[7:0];
				`OFF_RESUME2:  resume_char_second <= pwdata[7:0];
				default:       ;
			endcase
		end
	end

	// Guarded modem-control bits keep their value while the enhanced bit is clear.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			modem_control <= `RST_BYTE;
		else if (clock_en && wr && paddr == `OFF_MODEM_CTL && enhanced_feature[`EF_ENHANCED])
			modem_control <= pwdata[7:0];
		else if (clock_en && wr && paddr == `OFF_MODEM_CTL)
			modem_control <= {modem_control[7:5], pwdata[4], modem_control[3:2], pwdata[1:0]};
	end

	// Special-character flag: hardware set beats the read clear.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			interrupt_status <= `RST_BYTE;
		else if (clock_en && rd && paddr == `OFF_INT_STAT && prdata[`IS_SPECIAL])
			interrupt_status[`IS_SPECIAL] <= special_hit;
		else if (clock_en && special_hit)
			interrupt_status[`IS_SPECIAL] <= 1'b1;
	end

	// Last control character seen in each direction; only bits that were read clear.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			flow_char_status <= `RST_BYTE;
		else if (clock_en && enhanced_feature[3:0] == 4'h0)
			flow_char_status <= 8'h00;
		else if (clock_en)
		begin
			if (rd && paddr == `OFF_FLOW_STAT)
				flow_char_status[3:0] <= flow_char_status[3:0] & ~prdata[3:0];
			if (tx_sent_xon || tx_sent_xoff)
				flow_char_status[3:2] <= {tx_sent_xon, tx_sent_xoff && !tx_sent_xon};
			if (xon_hit || xoff_hit)
				flow_char_status[1:0] <= {xon_hit, xoff_hit && !xon_hit};
		end
	end

	// Deassert and reassert marks around the receive trigger; table D with a nonzero code takes its offset from the code table.
	always_comb
	begin
		hyst = (feature_control[7:6] == `TABLE_D && feature_control[3:0] != 4'h0)
			? 8'(`HYST_TABLE >> {feature_control[3:0], 3'b000}) : `NEXT_STEP;
		hi_mark = {1'b0, rx_fifo_trigger} + {1'b0, hyst};
		lo_mark = (rx_fifo_trigger > hyst) ? rx_fifo_trigger - hyst : 8'h01;
	end

	// Automatic receive-side stop request with hysteresis.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			auto_stop <= 1'b0;
		else if (clock_en && {1'b0, rx_fifo_level_count} >= hi_mark)
			auto_stop <= 1'b1;
		else if (clock_en && rx_fifo_level_count < lo_mark)
			auto_stop <= 1'b0;
	end

	// Remote xoff halts the transmitter until xon, while receive compare is on.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			remote_stop <= 1'b0;
		else if (clock_en && (enhanced_feature[1:0] == 2'b00 || xon_hit))
			remote_stop <= 1'b0;
		else if (clock_en && xoff_hit)
			remote_stop <= 1'b1;
	end

	// Handshake pins and transmit halt.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			{rts_n, dtr_n, tx_stop, tx_flow_sel} <= 5'b11000;
		else if (clock_en)
		begin
			rts_n <= !modem_control[`MC_RTS] || (enhanced_feature[`EF_AUTO_RTS]
				&& !modem_control[`MC_SELECT] && auto_stop);
			dtr_n <= !modem_control[`MC_DTR] || (enhanced_feature[`EF_AUTO_RTS]
				&& modem_control[`MC_SELECT] && auto_stop);
			tx_stop <= (enhanced_feature[`EF_AUTO_CTS]
				&& (modem_control[`MC_SELECT] ? pin_f[1] : pin_f[0])) || remote_stop;
			tx_flow_sel <= enhanced_feature[3:2];
		end
	end

	// FIFO level counters, bounded to the FIFO depth.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			{tx_fifo_level_count, rx_fifo_level_count} <= {`RST_BYTE, `RST_BYTE};
		else if (clock_en)
		begin
			tx_fifo_level_count <= tx_fifo_level_count
				+ {7'h00, tx_push && tx_fifo_level_count < `FIFO_DEPTH}
				- {7'h00, tx_pop && tx_fifo_level_count != 8'h00};
			rx_fifo_level_count <= rx_fifo_level_count
				+ {7'h00, rx_store_valid && rx_fifo_level_count < `FIFO_DEPTH}
				- {7'h00, rx_pop && rx_fifo_level_count != 8'h00};
		end
	end

	// Level interrupts and the special-character interrupt line.
	always_ff @(posedge clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			{tx_level_irq, rx_level_irq, special_irq} <= 3'b000;
		else if (clock_en)
		begin
			tx_level_irq <= tx_fifo_level_count < tx_fifo_trigger;
			rx_level_irq <= rx_fifo_level_count >= rx_fifo_trigger;
			special_irq  <= interrupt_status[`IS_SPECIAL];
		end
	end

	// Receive character compare and FIFO store decision.
	flow_char_match u_match (
		.clock       (clock),
		.rst_n       (rst_sync_n),
		.clock_en    (clock_en),
		.tx_mode     (enhanced_feature[3:2]),
		.rx_mode     (enhanced_feature[1:0]),
		.special_en  (enhanced_feature[`EF_SPECIAL]),
		.stop1       (stop_char_first),
		.stop2       (stop_char_second),
		.resume1     (resume_char_first),
		.resume2     (resume_char_second),
		.char_valid  (rx_valid),
		.char_in     (rx_char),
		.xon_hit     (xon_hit),
		.xoff_hit    (xoff_hit),
		.special_hit (special_hit),
		.store_valid (rx_store_valid),
		.store_char  (rx_store_char)
	);

	// Checks on the flow-control behaviour.
	default clocking cb @(posedge clock iff clock_en); endclocking
	default disable iff (!rst_sync_n);

	sequence s_mcr_write_locked;
		wr && paddr == `OFF_MODEM_CTL && !enhanced_feature[`EF_ENHANCED];
	endsequence

	property p_rx_irq;
		rx_fifo_level_count >= rx_fifo_trigger |=> rx_level_irq;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx level irq missing");
	property p_tx_irq;
		tx_fifo_level_count < tx_fifo_trigger |=> tx_level_irq;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx level irq missing");
	property p_tx_bound;
		tx_fifo_level_count <= `FIFO_DEPTH;
	endproperty
	a_tx_bound: assert property (p_tx_bound) else $error("tx count above depth");
	property p_rx_bound;
		rx_fifo_level_count <= `FIFO_DEPTH;
	endproperty
	a_rx_bound: assert property (p_rx_bound) else $error("rx count above depth");
	property p_stat_off;
		enhanced_feature[3:0] == 4'h0 |=> flow_char_status == 8'h00;
	endproperty
	a_stat_off: assert property (p_stat_off) else $error("flow status not cleared");
	property p_gp_rts;
		!enhanced_feature[`EF_AUTO_RTS] |=> rts_n == !$past(modem_control[`MC_RTS]);
	endproperty
	a_gp_rts: assert property (p_gp_rts) else $error("rts not under software");
	property p_lock;
		s_mcr_write_locked |=> modem_control[3:2] == $past(modem_control[3:2]);
	endproperty
	a_lock: assert property (p_lock) else $error("guarded bits changed");
	property p_auto_cts;
		enhanced_feature[`EF_AUTO_CTS] && !modem_control[`MC_SELECT] && pin_f[0] |=> tx_stop;
	endproperty
	a_auto_cts: assert property (p_auto_cts) else $error("transmitter not halted");
	property p_auto_rts;
		{1'b0, rx_fifo_level_count} >= hi_mark ##1 enhanced_feature[`EF_AUTO_RTS]
			&& !modem_control[`MC_SELECT] |=> rts_n;
	endproperty
	a_auto_rts: assert property (p_auto_rts) else $error("rts not deasserted");
endmodule // uart_flow_ctrl
`default_nettype wire

// >>> modem_partner.sv
// Modem partner that drives the handshake inputs of the flow-control block.
// Assumes the bench commands when it stalls and whether it answers slowly.
`timescale 1ns/1ps
`default_nettype none
module modem_partner (
	input  wire logic       clock,
	input  wire logic [1:0] hold,
	input  wire logic       slow,
	output logic            cts_n,
	output logic            dsr_n
);
	logic [1:0] late;
	// The lines start asserted so the block sees a ready partner from time zero.
	initial
	begin
		late  = 2'b00;
		cts_n = 1'b0;
		dsr_n = 1'b0;
	end
	// A stalled partner drives its line high; a slow one answers a cycle later.
	always @(posedge clock)
	begin
		late  <= hold;
		cts_n <= slow ? late[0] : hold[0];
		dsr_n <= slow ? late[1] : hold[1];
	end
endmodule // modem_partner
`default_nettype wire

// >>> uart_flow_ctrl_tb_top.sv
// Self-checking bench for the UART flow-control block and its modem partner.
// Assumes the offsets of the shared header and an APB slave with no wait states.
`include "uart_flow_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_flow_ctrl_tb_top;
	import uart_flow_pkg::*;
	logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr, cts_n, dsr_n, rts_n, dtr_n, tx_stop;
	logic [1:0]  tx_flow_sel, hold = 0;
	logic        slow = 0, tx_push = 0, tx_pop = 0, rx_pop = 0, rx_valid = 0, clock_en = 1;
	logic        tx_sent_xon = 0, tx_sent_xoff = 0, rx_store_valid;
	logic        tx_level_irq, rx_level_irq, special_irq;
	byte_t       rx_char = 0, rx_store_char;
	int          bad_count = 0, n_compared = 0, t, k, lvl;
	byte_t       rxq[$];
	int          hy[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
	byte_t       fv[6] = '{8'h00, 8'h80, 8'hc0, 8'hc5, 8'hcc, 8'hcb};
	int          tv[6] = '{8, 12, 6, 20, 16, 8};
	// The clock toggles every 4 ns, half of its 8 ns period.
	always #4 clock = ~clock;
	uart_flow_ctrl u_uart_flow_ctrl (.clock(clock), .rst_n(rst_n), .clock_en(clock_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n),
		.dtr_n(dtr_n), .tx_stop(tx_stop), .tx_flow_sel(tx_flow_sel), .tx_push(tx_push),
		.tx_pop(tx_pop), .rx_pop(rx_pop), .tx_sent_xon(tx_sent_xon), .tx_sent_xoff(tx_sent_xoff),
		.rx_valid(rx_valid), .rx_char(rx_char), .rx_store_valid(rx_store_valid),
		.rx_store_char(rx_store_char), .tx_level_irq(tx_level_irq), .rx_level_irq(rx_level_irq),
		.special_irq(special_irq));
	modem_partner u_modem_partner (.clock(clock), .hold(hold), .slow(slow), .cts_n(cts_n), .dsr_n(dsr_n));
	// Prints the counts and the verdict, then ends the run.
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Compares one observed value with its expectation.
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input byte_t d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk(n < 40, 1, "no pready");
	endtask
	task automatic wr(input logic [7:0] a, input byte_t d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h00, r, e);
		chk(r, x, "read data");
		chk(e, xe, "slave error");
	endtask
	// Sends one received character and checks whether it reaches the FIFO.
	task automatic rxc(input byte_t c, input logic keep);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_char  <= c;
		@(posedge clock);
		rx_valid <= 1'b0;
		@(posedge clock);
		chk(rx_store_valid, keep, "store");
		if (keep)
		begin
			chk(rx_store_char, c, "stored char");
			rxq.push_back(c);
		end
		tick(3);
	endtask
	// Fills the receive FIFO past the stop point, then drains it empty, checking the resume point.
	task automatic fill(input byte_t f, input int tr);
		int h, lo;
		logic up;
		h = (f[7:6] == `TABLE_D && f[3:0] != 4'h0) ? hy[f[3:0]] : 4;
		lo = (tr - h > 1) ? tr - h : 1;
		up = 1'b0;
		wr(`OFF_FEATURE, f);
		wr(`OFF_RX_TRIG, tr[7:0]);
		rd(`OFF_FEATURE, {24'h0, f}, 1'b0);
		while (rxq.size() < tr + h + 1)
		begin
			rxc(8'h40 + $urandom_range(31, 0), 1'b1);
			if (rxq.size() >= tr + h)
				up = 1'b1;
			chk(rts_n, up, "rts stop");
			chk(rx_level_irq, rxq.size() >= tr, "rx irq");
		end
		chk(dtr_n, 1'b0, "dtr");
		rd(`OFF_RX_COUNT, rxq.size(), 1'b0);
		while (rxq.size() > 0)
		begin
			rx_pop <= 1'b1;
			tick(1);
			rx_pop <= 1'b0;
			void'(rxq.pop_front());
			tick(3);
			if (rxq.size() < lo)
				up = 1'b0;
			chk(rts_n, up, "rts resume");
		end
	endtask
	// Cuts a hung run short.
	initial
	begin
		#200000;
		bad_count++;
		end_of_test;
	end
	// Main sequence of tests.
	initial
	begin
		t = $urandom(92);
		tick(6);
		rst_n <= 1'b1;
		tick(4);
		foreach (tv[i])
			rd(8'(4 * i), 0, 1'b0);
		rd(`OFF_FLOW_STAT, 0, 1'b0);
		rd(`OFF_MODEM_CTL, 0, 1'b0);
		rd(8'h3c, 0, 1'b1);
		chk({rts_n, dtr_n}, 2'b11, "reset pins");
		$display("reset test done");
		wr(`OFF_MODEM_CTL, 8'hff);
		rd(`OFF_MODEM_CTL, 8'h13, 1'b0);
		chk({rts_n, dtr_n}, 2'b00, "gp out");
		wr(`OFF_ENHANCED, 8'h10);
		wr(`OFF_MODEM_CTL, 8'he7);
		rd(`OFF_MODEM_CTL, 8'he7, 1'b0);
		wr(`OFF_ENHANCED, 8'h00);
		wr(`OFF_MODEM_CTL, 8'h00);
		rd(`OFF_MODEM_CTL, 8'he4, 1'b0);
		tick(2);
		chk({rts_n, dtr_n}, 2'b11, "gp off");
		$display("guard test done");
		t = $urandom_range(63, 1);
		wr(`OFF_TX_TRIG, t[7:0]);
		rd(`OFF_TX_TRIG, 0, 1'b0);
		// Pushes while the clock enable is low must leave the level untouched.
		clock_en <= 1'b0;
		tx_push  <= 1'b1;
		tick(5);
		{clock_en, tx_push} <= 2'b10;
		rd(`OFF_TX_COUNT, 0, 1'b0);
		tx_push <= 1'b1;
		tick(64);
		tx_push <= 1'b0;
		tick(3);
		rd(`OFF_TX_COUNT, 32'h40, 1'b0);
		chk(tx_level_irq, 1'b0, "tx irq full");
		for (lvl = 64; lvl > 0; lvl -= k)
		begin
			k = $urandom_range(8, 1);
			k = (k > lvl) ? lvl : k;
			tx_pop <= 1'b1;
			tick(k);
			tx_pop <= 1'b0;
			tick(3);
			chk(tx_level_irq, lvl - k < t, "tx irq");
		end
		rd(`OFF_TX_COUNT, 0, 1'b0);
		$display("tx level test done");
		wr(`OFF_ENHANCED, 8'h90);
		for (int s = 0; s < 4; s++)
		begin
			wr(`OFF_MODEM_CTL, {5'h0, s[1], 2'b00});
			hold <= 2'b01 << s[0];
			slow <= s[0];
			tick(10);
			chk(tx_stop, s[1] == s[0], "halt");
			hold <= 2'b00;
			tick(10);
			chk(tx_stop, 1'b0, "resume");
		end
		$display("auto cts test done");
		wr(`OFF_ENHANCED, 8'h50);
		wr(`OFF_MODEM_CTL, 8'h03);
		foreach (fv[i])
			fill(fv[i], tv[i]);
		$display("auto rts test done");
		for (int m = 0; m < 4; m++)
		begin
			wr(`OFF_ENHANCED, {4'h1, m[1:0], 2'b00});
			tick(2);
			chk(tx_flow_sel, m[1:0], "tx sel");
			wr(`OFF_ENHANCED, 8'h10);
		end
		wr(`OFF_STOP1, 8'h13);
		wr(`OFF_STOP2, 8'h93);
		wr(`OFF_RESUME1, 8'h11);
		wr(`OFF_RESUME2, 8'h91);
		rd(`OFF_STOP2, 0, 1'b0);
		wr(`OFF_ENHANCED, 8'h12);
		rxc(8'h13, 1'b0);
		chk(tx_stop, 1'b1, "xoff");
		rd(`OFF_FLOW_STAT, 8'h01, 1'b0);
		rd(`OFF_FLOW_STAT, 8'h00, 1'b0);
		rxc(8'h93, 1'b1);
		rxc(8'h11, 1'b0);
		chk(tx_stop, 1'b0, "xon");
		tx_sent_xon <= 1'b1;
		tick(1);
		tx_sent_xon <= 1'b0;
		tick(2);
		rd(`OFF_FLOW_STAT, 8'h0a, 1'b0);
		tx_sent_xoff <= 1'b1;
		tick(1);
		tx_sent_xoff <= 1'b0;
		tick(2);
		rd(`OFF_FLOW_STAT, 8'h04, 1'b0);
		wr(`OFF_ENHANCED, 8'h10);
		wr(`OFF_ENHANCED, 8'h32);
		rxc(8'h93, 1'b1);
		chk(special_irq, 1'b1, "special");
		rd(`OFF_INT_STAT, 8'h10, 1'b0);
		wr(`OFF_ENHANCED, 8'h10);
		wr(`OFF_ENHANCED, 8'h31);
		rxc(8'h93, 1'b0);
		chk({special_irq, tx_stop}, 2'b11, "special xoff");
		rd(`OFF_INT_STAT, 8'h10, 1'b0);
		wr(`OFF_ENHANCED, 8'h10);
		wr(`OFF_ENHANCED, 8'h1b);
		rxc(8'h93, 1'b0);
		chk(tx_stop, 1'b1, "either xoff");
		rxc(8'h91, 1'b0);
		chk(tx_stop, 1'b0, "either xon");
		wr(`OFF_ENHANCED, 8'h10);
		rd(`OFF_FLOW_STAT, 8'h00, 1'b0);
		wr(`OFF_ENHANCED, 8'h13);
		rxc(8'h11, 1'b1);
		rxc(8'h91, 1'b0);
		rd(`OFF_FLOW_STAT, 8'h02, 1'b0);
		$display("soft flow test done");
		end_of_test;
	end
endmodule // uart_flow_ctrl_tb_top
`default_nettype wire
